// ### design/ivf_pkg.sv
// constants and carrier types for the interrupt vector and fast irq block
package ivf_pkg;
  // bus and vector geometry
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned NUM_VEC     = 64;
  localparam int unsigned VEC_W       = 6;
  localparam int unsigned VADDR_W     = 21;
  localparam int unsigned BASE_W      = 14;
  localparam int unsigned OFFS_W      = 7;
  localparam int unsigned HIGH_W      = 5;
  localparam int unsigned PRIO_REGS   = 8;

  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_VECTOR_BASE   = 6'h07;
  localparam logic [5:0] IDX_SLOT0_SELECT  = 6'h08;
  localparam logic [5:0] IDX_SLOT0_LOW     = 6'h09;
  localparam logic [5:0] IDX_SLOT0_HIGH    = 6'h0a;
  localparam logic [5:0] IDX_SLOT1_SELECT  = 6'h0b;
  localparam logic [5:0] IDX_SLOT1_LOW     = 6'h0c;
  localparam logic [5:0] IDX_SLOT1_HIGH    = 6'h0d;
  localparam logic [5:0] IDX_PENDING_LOW   = 6'h0e;
  localparam logic [5:0] IDX_PRIO_FIRST    = 6'h20;
  localparam logic [5:0] IDX_EVENT_STATUS  = 6'h28;
  localparam logic [5:0] IDX_EVENT_MASK    = 6'h29;

  // reset values
  localparam logic [13:0] VBASE_RESET_A    = 14'h0000;
  localparam logic [13:0] VBASE_RESET_B    = 14'h0080;
  localparam logic [15:0] PENDING_RESET    = 16'hffff;
  localparam logic [1:0]  PRIO_DISABLED    = 2'h0;
  localparam logic [1:0]  PRIO_LEVEL2_CODE = 2'h3;

  // pending register covers vectors 2..16 in bits 15..1
  localparam int unsigned PEND_FIRST_VEC   = 2;
  localparam int unsigned PEND_LAST_VEC    = 16;

  // event status bits
  localparam int unsigned EV_SLOT0  = 0;
  localparam int unsigned EV_SLOT1  = 1;
  localparam int unsigned EV_TAKEN  = 2;
  localparam int unsigned EV_W      = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // vector presented to the core
  typedef struct packed {
    logic                request;
    logic [1:0]          level;
    logic                fast;
    logic [VADDR_W-1:0]  address;
  } ivf_vector_type;
endpackage : ivf_pkg

// ### design/ivf_core.sv
// vector generation, fast interrupt slots and axi4-lite register file
// Functional notes
// - vector base bits 13..0 form the top 14 bits of the 21-bit vector
// - low 7 vector bits are the winning irq number in 6..1 over a zero bit 0, appended below the base
// - base resets to zero or 0x0080 by variant; bits 15..14 read zero
// - slot 0 select holds a 6-bit vector number, upper bits zero, resets zero
// - slot 1 select holds a 6-bit vector number, upper bits zero, resets zero
// - a taken fast irq presents its slot address instead of base plus offset
// - a fast irq outranks every other level-2 irq
// - slot 0 wins over slot 1 when both are pending
// - slot 0 address is its high register over its low register
// - slot 1 address is its high register over its low register
// - high registers hold 5 bits in 4..0, rest zero, reset zero
// - low registers hold 16 read-write bits, reset zero
// - read-only pending register shows vectors 2..16, bit 0 one, resets ones
// - pending flags are active low, ascending vector to ascending bit
// - 2-bit priority code: 00 disabled, 01..11 levels 0..2, reset disabled
`timescale 1ns/10ps
`default_nettype none
module ivf_core #(
  parameter bit VARIANT_HIGH_BASE = 1'b0
) (
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic [ivf_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [ivf_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic [ivf_pkg::NUM_VEC-1:0]   irq_req,
  input  wire logic                          core_ack,
  output ivf_pkg::ivf_vector_type            vector_out,
  output logic                               irq_out
);

  // variant decides the base reset value
  localparam logic [13:0] VBASE_RESET =
    VARIANT_HIGH_BASE ? ivf_pkg::VBASE_RESET_B : ivf_pkg::VBASE_RESET_A;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = d[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = d[15:8];
    end
  endfunction

  // priority code to level, valid only when enabled
  function automatic logic [1:0] code_level(input logic [1:0] code);
    code_level = 2'(code - 2'h1);
  endfunction

  // word index from a byte address
  function automatic logic [5:0] word_index(input logic [ivf_pkg::ADDR_W-1:0] a);
    word_index = a[7:2];
  endfunction

  // register state
  logic [13:0]                 vector_base, next_vector_base;
  logic [5:0]                  fast_slot0_select, next_fast_slot0_select;
  logic [5:0]                  fast_slot1_select, next_fast_slot1_select;
  logic [15:0]                 fast_slot0_addr_low, next_fast_slot0_addr_low;
  logic [15:0]                 fast_slot1_addr_low, next_fast_slot1_addr_low;
  logic [4:0]                  fast_slot0_addr_high, next_fast_slot0_addr_high;
  logic [4:0]                  fast_slot1_addr_high, next_fast_slot1_addr_high;
  logic [1:0]                  priority_level [ivf_pkg::NUM_VEC];
  logic [1:0]                  next_priority_level [ivf_pkg::NUM_VEC];
  logic [15:0]                 pending_flags_low, next_pending_flags_low;
  logic [ivf_pkg::EV_W-1:0]    event_status, next_event_status;
  logic [ivf_pkg::EV_W-1:0]    event_mask, next_event_mask;

  // bus state
  logic                        aw_held, next_aw_held;
  logic [ivf_pkg::ADDR_W-1:0]  aw_addr, next_aw_addr;
  logic                        w_held, next_w_held;
  logic [31:0]                 w_data, next_w_data;
  logic [3:0]                  w_strb, next_w_strb;
  logic                        bvalid, next_bvalid;
  logic [1:0]                  bresp, next_bresp;
  logic                        rvalid, next_rvalid;
  logic [31:0]                 rdata, next_rdata;
  logic [1:0]                  rresp, next_rresp;

  // arbitration results
  ivf_pkg::ivf_vector_type     vec, next_vec;
  logic                        found;
  logic [1:0]                  best_level;
  logic [5:0]                  best_vec;
  logic                        slot0_hit, slot1_hit;
  logic [20:0]                 slot0_addr, slot1_addr;
  logic                        do_write;
  logic [5:0]                  widx;
  logic [5:0]                  ridx;

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;
  assign vector_out    = vec;
  // level output, high while any unmasked event is latched
  assign irq_out       = |(event_status & event_mask);

  // both halves of a write are held before it takes effect
  assign do_write = aw_held && w_held && !bvalid;
  assign widx     = word_index(aw_addr);
  assign ridx     = word_index(s_axi_araddr);

  // fast slot service addresses
  assign slot0_addr = {fast_slot0_addr_high, fast_slot0_addr_low};
  assign slot1_addr = {fast_slot1_addr_high, fast_slot1_addr_low};

  // normal ordering: highest level, then lowest vector number
  always_comb begin
    found      = 1'b0;
    best_level = 2'h0;
    best_vec   = 6'h00;
    for (int v = ivf_pkg::NUM_VEC - 1; v >= 0; v--) begin
      if (irq_req[v] && priority_level[v] != ivf_pkg::PRIO_DISABLED) begin
        if (!found || code_level(priority_level[v]) >= best_level) begin
          found      = 1'b1;
          best_level = code_level(priority_level[v]);
          best_vec   = 6'(v);
        end
      end
    end
  end

  // a fast slot counts only when its irq is requesting at level 2
  always_comb begin
    slot0_hit = irq_req[fast_slot0_select] &&
                priority_level[fast_slot0_select] == ivf_pkg::PRIO_LEVEL2_CODE;
    slot1_hit = irq_req[fast_slot1_select] &&
                priority_level[fast_slot1_select] == ivf_pkg::PRIO_LEVEL2_CODE;
  end

  // vector selection; fast slots jump past the table
  always_comb begin
    next_vec         = vec;
    next_vec.request = found;
    next_vec.level   = best_level;
    next_vec.fast    = 1'b0;
    if (slot0_hit) begin
      next_vec.fast    = 1'b1;
      next_vec.address = slot0_addr;
    end else if (slot1_hit) begin
      next_vec.fast    = 1'b1;
      next_vec.address = slot1_addr;
    end else if (found) begin
      next_vec.address = {vector_base, best_vec, 1'b0};
    end else begin
      next_vec.address = {vector_base, 7'h00};
    end
  end

  // pending snapshot, active low, vectors 2..16 on bits 15..1
  always_comb begin
    next_pending_flags_low    = ivf_pkg::PENDING_RESET;
    for (int v = ivf_pkg::PEND_FIRST_VEC; v <= ivf_pkg::PEND_LAST_VEC; v++) begin
      next_pending_flags_low[v-1] = !(irq_req[v] &&
                                      priority_level[v] != ivf_pkg::PRIO_DISABLED);
    end
    next_pending_flags_low[0] = 1'b1;
  end

  // register writes and event flags; a new event beats a clear
  always_comb begin
    next_vector_base          = vector_base;
    next_fast_slot0_select    = fast_slot0_select;
    next_fast_slot1_select    = fast_slot1_select;
    next_fast_slot0_addr_low  = fast_slot0_addr_low;
    next_fast_slot1_addr_low  = fast_slot1_addr_low;
    next_fast_slot0_addr_high = fast_slot0_addr_high;
    next_fast_slot1_addr_high = fast_slot1_addr_high;
    next_priority_level       = priority_level;
    next_event_mask           = event_mask;
    next_event_status         = event_status;
    if (do_write) begin
      case (widx)
        ivf_pkg::IDX_VECTOR_BASE:
          next_vector_base = 14'(merge16({2'h0, vector_base}, w_data, w_strb));
        ivf_pkg::IDX_SLOT0_SELECT:
          next_fast_slot0_select = 6'(merge16({10'h000, fast_slot0_select}, w_data,
                                              w_strb));
        ivf_pkg::IDX_SLOT1_SELECT:
          next_fast_slot1_select = 6'(merge16({10'h000, fast_slot1_select}, w_data,
                                              w_strb));
        ivf_pkg::IDX_SLOT0_LOW:
          next_fast_slot0_addr_low = merge16(fast_slot0_addr_low, w_data, w_strb);
        ivf_pkg::IDX_SLOT1_LOW:
          next_fast_slot1_addr_low = merge16(fast_slot1_addr_low, w_data, w_strb);
        ivf_pkg::IDX_SLOT0_HIGH:
          next_fast_slot0_addr_high = 5'(merge16({11'h000, fast_slot0_addr_high}, w_data,
                                                 w_strb));
        ivf_pkg::IDX_SLOT1_HIGH:
          next_fast_slot1_addr_high = 5'(merge16({11'h000, fast_slot1_addr_high}, w_data,
                                                 w_strb));
        ivf_pkg::IDX_EVENT_MASK:
          if (w_strb[0]) begin
            next_event_mask = w_data[ivf_pkg::EV_W-1:0];
          end
        ivf_pkg::IDX_EVENT_STATUS:
          if (w_strb[0]) begin
            next_event_status = event_status & ~w_data[ivf_pkg::EV_W-1:0];
          end
        default: begin
          for (int k = 0; k < ivf_pkg::PRIO_REGS; k++) begin
            if (widx == 6'(ivf_pkg::IDX_PRIO_FIRST + k)) begin
              for (int j = 0; j < 8; j++) begin
                if (w_strb[j/4]) begin
                  next_priority_level[k*8+j] = w_data[2*j +: 2];
                end
              end
            end
          end
        end
      endcase
    end
    // core acknowledge of a presented vector raises events
    if (core_ack && vec.request) begin
      next_event_status[ivf_pkg::EV_TAKEN] = 1'b1;
    end
    if (core_ack && vec.fast && slot0_addr == vec.address) begin
      next_event_status[ivf_pkg::EV_SLOT0] = 1'b1;
    end else if (core_ack && vec.fast) begin
      next_event_status[ivf_pkg::EV_SLOT1] = 1'b1;
    end
  end

  // bus channel bookkeeping and read mux
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = ivf_pkg::RESP_OKAY;
      // pending register is read only, writes to it are refused
      if (widx == ivf_pkg::IDX_PENDING_LOW || widx < ivf_pkg::IDX_VECTOR_BASE ||
          (widx > ivf_pkg::IDX_PENDING_LOW && widx < ivf_pkg::IDX_PRIO_FIRST) ||
          widx > ivf_pkg::IDX_EVENT_MASK) begin
        next_bresp = ivf_pkg::RESP_SLVERR;
      end
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = ivf_pkg::RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      case (ridx)
        ivf_pkg::IDX_VECTOR_BASE:  next_rdata[13:0] = vector_base;
        ivf_pkg::IDX_SLOT0_SELECT: next_rdata[5:0]  = fast_slot0_select;
        ivf_pkg::IDX_SLOT1_SELECT: next_rdata[5:0]  = fast_slot1_select;
        ivf_pkg::IDX_SLOT0_LOW:    next_rdata[15:0] = fast_slot0_addr_low;
        ivf_pkg::IDX_SLOT1_LOW:    next_rdata[15:0] = fast_slot1_addr_low;
        ivf_pkg::IDX_SLOT0_HIGH:   next_rdata[4:0]  = fast_slot0_addr_high;
        ivf_pkg::IDX_SLOT1_HIGH:   next_rdata[4:0]  = fast_slot1_addr_high;
        ivf_pkg::IDX_PENDING_LOW:  next_rdata[15:0] = pending_flags_low;
        ivf_pkg::IDX_EVENT_STATUS: next_rdata[ivf_pkg::EV_W-1:0] = event_status;
        ivf_pkg::IDX_EVENT_MASK:   next_rdata[ivf_pkg::EV_W-1:0] = event_mask;
        default: begin
          next_rresp = ivf_pkg::RESP_SLVERR;
          for (int k = 0; k < ivf_pkg::PRIO_REGS; k++) begin
            if (ridx == 6'(ivf_pkg::IDX_PRIO_FIRST + k)) begin
              next_rresp = ivf_pkg::RESP_OKAY;
              for (int j = 0; j < 8; j++) begin
                next_rdata[2*j +: 2] = priority_level[k*8+j];
              end
            end
          end
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // all state registers; reset vector is the base with a zero offset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vector_base          <= VBASE_RESET;
      fast_slot0_select    <= 6'h00;
      fast_slot1_select    <= 6'h00;
      fast_slot0_addr_low  <= 16'h0000;
      fast_slot1_addr_low  <= 16'h0000;
      fast_slot0_addr_high <= 5'h00;
      fast_slot1_addr_high <= 5'h00;
      for (int v = 0; v < ivf_pkg::NUM_VEC; v++) begin
        priority_level[v] <= ivf_pkg::PRIO_DISABLED;
      end
      pending_flags_low    <= ivf_pkg::PENDING_RESET;
      event_status         <= '0;
      event_mask           <= '0;
      aw_held              <= 1'b0;
      aw_addr              <= '0;
      w_held               <= 1'b0;
      w_data               <= 32'h0000_0000;
      w_strb               <= 4'h0;
      bvalid               <= 1'b0;
      bresp                <= 2'h0;
      rvalid               <= 1'b0;
      rdata                <= 32'h0000_0000;
      rresp                <= 2'h0;
      vec                  <= '{request: 1'b0, level: 2'h0, fast: 1'b0,
                                address: {VBASE_RESET, 7'h00}};
    end else begin
      vector_base          <= next_vector_base;
      fast_slot0_select    <= next_fast_slot0_select;
      fast_slot1_select    <= next_fast_slot1_select;
      fast_slot0_addr_low  <= next_fast_slot0_addr_low;
      fast_slot1_addr_low  <= next_fast_slot1_addr_low;
      fast_slot0_addr_high <= next_fast_slot0_addr_high;
      fast_slot1_addr_high <= next_fast_slot1_addr_high;
      priority_level       <= next_priority_level;
      pending_flags_low    <= next_pending_flags_low;
      event_status         <= next_event_status;
      event_mask           <= next_event_mask;
      aw_held              <= next_aw_held;
      aw_addr              <= next_aw_addr;
      w_held               <= next_w_held;
      w_data               <= next_w_data;
      w_strb               <= next_w_strb;
      bvalid               <= next_bvalid;
      bresp                <= next_bresp;
      rvalid               <= next_rvalid;
      rdata                <= next_rdata;
      rresp                <= next_rresp;
      vec                  <= next_vec;
    end
  end

endmodule // ivf_core
`default_nettype wire

// ### sim/ivf_core_model.sv
// processor core model that takes presented vectors
`timescale 1ns/10ps
`default_nettype none
module ivf_core_model #(
  parameter int unsigned LAG = 2
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire ivf_pkg::ivf_vector_type vector_out,
  input  wire logic                    accept_en,
  output logic                         core_ack
);
  logic [3:0] wait_cnt;
  logic [3:0] next_wait_cnt;
  logic       next_core_ack;

  // waits LAG cycles on a request, then pulses ack once; bench gates it so events stay countable
  always_comb begin
    next_wait_cnt = 4'h0;
    next_core_ack = 1'b0;
    if (accept_en && vector_out.request && !core_ack) begin
      if (wait_cnt == LAG[3:0]) next_core_ack = 1'b1;
      else next_wait_cnt = wait_cnt + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 4'h0;
      core_ack <= 1'b0;
    end else begin
      wait_cnt <= next_wait_cnt;
      core_ack <= next_core_ack;
    end
  end
endmodule // ivf_core_model
`default_nettype wire

// ### sim/ivf_core_monitor.sv
// concurrent checks on the vector block ports
`timescale 1ns/10ps
`default_nettype none
module ivf_core_monitor (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        s_axi_awready,
  input  wire logic                        s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic                        s_axi_arvalid,
  input  wire logic                        s_axi_arready,
  input  wire logic [31:0]                 s_axi_rdata,
  input  wire logic                        s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [ivf_pkg::NUM_VEC-1:0] irq_req,
  input  wire ivf_pkg::ivf_vector_type     vector_out
);
  logic [ivf_pkg::NUM_VEC-1:0] req_d;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // requests as the vector logic saw them one edge earlier
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) req_d <= '0;
    else req_d <= irq_req;
  end

  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_gate_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  write_gate_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write accepted while busy");
  fast_level_a: assert property (vector_out.fast |-> vector_out.request && vector_out.level == 2'h2)
    else $error("fast vector not level 2");
  idle_vector_a: assert property (irq_req == '0 |=> !vector_out.request)
    else $error("request without source");
  normal_src_a: assert property (vector_out.request && !vector_out.fast |-> req_d[vector_out.address[6:1]] && !vector_out.address[0])
    else $error("offset not from requester");
  fast_src_a: assert property (vector_out.fast |-> |req_d)
    else $error("fast vector without source");
endmodule // ivf_core_monitor

bind ivf_core ivf_core_monitor mon (
  .mclk(mclk), .rst_n(rst_n), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .irq_req(irq_req), .vector_out(vector_out)
);
`default_nettype wire

// ### sim/tb.sv
// self-checking bench for the vector and fast irq block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                    mclk = 1'b0;
  logic                    rst_n = 1'b0;
  logic [7:0]              awaddr = 8'h00;
  logic [7:0]              araddr = 8'h00;
  logic [31:0]             wdata = 32'h0;
  logic                    awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                    arvalid = 1'b0, rready = 1'b0, accept_en = 1'b0;
  logic                    awready, wready, bvalid, arready, rvalid, irq_out, core_ack;
  logic [1:0]              bresp, rresp;
  logic [31:0]             rdata;
  logic [63:0]             irq_req = 64'h0;
  ivf_pkg::ivf_vector_type vector_out;
  ivf_pkg::ivf_vector_type vec_hb;
  int                      errors = 0;
  int                      check_count = 0;
  logic [15:0]             rmask [7:13] = '{16'h3fff, 16'h003f, 16'hffff, 16'h001f,
                                            16'h003f, 16'hffff, 16'h001f};
  localparam logic [1:0]   OK = ivf_pkg::RESP_OKAY;
  localparam logic [1:0]   ERR = ivf_pkg::RESP_SLVERR;

  ivf_core dut (
    .mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_req(irq_req), .core_ack(core_ack), .vector_out(vector_out), .irq_out(irq_out)
  );
  ivf_core_model #(.LAG(2)) core (.mclk(mclk), .rst_n(rst_n), .vector_out(vector_out),
    .accept_en(accept_en), .core_ack(core_ack));
  // second variant, idle bus, only its reset vector is watched
  ivf_core #(.VARIANT_HIGH_BASE(1'b1)) dut_hb (
    .mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(8'h00), .s_axi_awvalid(1'b0), .s_axi_awready(),
    .s_axi_wdata(32'h0), .s_axi_wstrb(4'h0), .s_axi_wvalid(1'b0), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(1'b0), .s_axi_araddr(8'h00),
    .s_axi_arvalid(1'b0), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready(1'b0), .irq_req(64'h0), .core_ack(1'b0), .vector_out(vec_hb), .irq_out()
  );

  initial begin
    forever #10 mclk = ~mclk;
  end

  task automatic give_verdict();
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [7:0] ba(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction

  // handshakes judged at the falling edge, where ready already holds its edge value
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    b = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !b; n++) begin
      @(negedge mclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      if (b) chk("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge mclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
    if (!b) begin
      chk("write timeout", 32'h1, 32'h0);
      give_verdict();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, r;
    r = 1'b0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !r; n++) begin
      @(negedge mclk);
      ar = arvalid && arready;
      r = rvalid;
      if (r) chk("rdata", ed, rdata);
      if (r) chk("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge mclk);
      if (ar) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
    end
    if (!r) begin
      chk("read timeout", 32'h1, 32'h0);
      give_verdict();
    end
  endtask

  // new requests, then the vector two edges later
  task automatic vset(input logic [63:0] rq, input logic f, input logic [1:0] lv,
                      input logic [20:0] ad);
    @(posedge mclk);
    irq_req <= rq;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("vector_out", {7'h0, 1'b1, lv, f, ad}, {7'h0, vector_out});
  endtask

  task automatic irq_chk(input logic e);
    @(negedge mclk);
    chk("irq_out", {31'h0, e}, {31'h0, irq_out});
  endtask

  task automatic s_reset();
    for (int i = 7; i < 14; i++) rd(ba(i[5:0]), 32'h0, OK);
    rd(ba(ivf_pkg::IDX_PENDING_LOW), 32'h0000ffff, OK);
    rd(8'hfc, 32'h0, ERR);
    chk("reset vector", {11'h0, ivf_pkg::VBASE_RESET_B, 7'h00}, {11'h0, vec_hb.address});
  endtask

  task automatic s_regs();
    for (int i = 7; i < 14; i++) wr(ba(i[5:0]), 32'hffffffff, OK);
    for (int i = 7; i < 14; i++) rd(ba(i[5:0]), {16'h0, rmask[i]}, OK);
    wr(ba(ivf_pkg::IDX_PENDING_LOW), 32'h0, ERR);
    rd(ba(ivf_pkg::IDX_PENDING_LOW), 32'h0000ffff, OK);
    wr(8'hfc, 32'h1, ERR);
  endtask

  // vector 3 at level 1 beats vector 5 at level 0; vector 7 left disabled
  task automatic s_vector();
    wr(ba(ivf_pkg::IDX_VECTOR_BASE), 32'h0123, OK);
    wr(8'h80, 32'h0480, OK);
    vset(64'ha8, 1'b0, 2'h1, {14'h0123, 6'd3, 1'b0});
    rd(ba(ivf_pkg::IDX_PENDING_LOW), 32'h0000ffeb, OK);
    vset(64'ha0, 1'b0, 2'h0, {14'h0123, 6'd5, 1'b0});
  endtask

  // vectors 2, 4 and 9 at level 2; 9 in slot 0, 4 in slot 1
  task automatic s_fast();
    wr(8'h80, 32'h0330, OK);
    wr(8'h84, 32'h000c, OK);
    wr(ba(8), 32'h9, OK);
    wr(ba(9), 32'habcd, OK);
    wr(ba(10), 32'h15, OK);
    wr(ba(11), 32'h4, OK);
    wr(ba(12), 32'h1234, OK);
    wr(ba(13), 32'h0a, OK);
    vset(64'h214, 1'b1, 2'h2, 21'h15abcd);
    vset(64'h014, 1'b1, 2'h2, 21'h0a1234);
    vset(64'h004, 1'b0, 2'h2, {14'h0123, 6'd2, 1'b0});
  endtask

  // slot 0 taken by the core sets status bits 0 and 2
  task automatic s_events();
    vset(64'h200, 1'b1, 2'h2, 21'h15abcd);
    @(posedge mclk);
    accept_en <= 1'b1;
    repeat (6) @(posedge mclk);
    accept_en <= 1'b0;
    rd(8'ha0, 32'h5, OK);
    irq_chk(1'b0);
    wr(8'ha4, 32'h1, OK);
    irq_chk(1'b1);
    wr(8'ha4, 32'h2, OK);
    irq_chk(1'b0);
    wr(8'ha0, 32'h1, OK);
    rd(8'ha0, 32'h4, OK);
    wr(8'ha4, 32'h4, OK);
    irq_chk(1'b1);
    wr(8'ha0, 32'h4, OK);
    irq_chk(1'b0);
    // slot 1 taken sets status bits 1 and 2
    vset(64'h010, 1'b1, 2'h2, 21'h0a1234);
    @(posedge mclk);
    accept_en <= 1'b1;
    repeat (6) @(posedge mclk);
    accept_en <= 1'b0;
    rd(8'ha0, 32'h6, OK);
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    s_reset();
    s_regs();
    s_vector();
    s_fast();
    s_events();
    give_verdict();
  end
endmodule // tb
`default_nettype wire
